// >>> rtl/pcrb_bank.sv
// I2C target and control/status register bank of the power management unit.
// Operation
// - Answer only the fixed seven-bit target address 7E on the serial port.
// - Result, reason, status registers and charger bits 3 and 4 are read-only.
// - Capture wake input levels into reason register at power-up start, then hold.
// - Reason bit is one when its input was high at start; several allowed.
// - Charger reason bit set only when a good battery is present.
// - Status register mirrors comparators, converter flags and wake inputs live.
// - Status bit 3 shows valid charger voltage present.
// - Comparator status bits are one while input exceeds threshold.
// - Key, alarm, handsfree status bits follow their pins directly.
// - Four-bit codes for regulators 1,2,4,9,10 step from 1.5 V.
// - Three-bit codes step from 2.5 V; regulator 11 steps from 1.8 V.
// - First enable register holds one enable bit per regulator 1 to 8.
// - Pair register: upper nibble regulator 9, lower nibble regulator 1.
// - Voltage codes are stored independently of enables.
// - Charger register bit 0 set disables the main charger.
// - Writes to read-only or unused bits change nothing and raise no error.
// - Two-bit end-of-charge field selects termination current.
// - Two-bit converter select routes battery, current or identity resistor.
module pcrb_bank (
    input  wire logic                     clk_sys_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_o,
    input  wire logic                     powerup_start_i,
    input  wire logic                     battery_good_i,
    input  wire logic                     on_key_i,
    input  wire logic                     alarm_i,
    input  wire logic                     charger_supply_input_i,
    input  wire logic                     handsfree_wake_input_i,
    input  wire logic                     comparator_one_result_i,
    input  wire logic                     comparator_two_result_i,
    input  wire logic                     adc_overflow_i,
    input  wire logic                     adc_ready_i,
    input  wire logic [7:0]               adc_data_i,
    input  wire logic                     eoc_flag_i,
    input  wire logic                     charging_i,
    output logic [7:0]                    reg_enable_o,
    output logic [3:0]                    vcode_reg1_o,
    output logic [3:0]                    vcode_reg2_o,
    output logic [2:0]                    vcode_reg3_o,
    output logic [3:0]                    vcode_reg4_o,
    output logic [2:0]                    vcode_reg5_o,
    output logic [2:0]                    vcode_reg6_o,
    output logic [2:0]                    vcode_reg7_o,
    output logic [2:0]                    vcode_reg8_o,
    output logic [3:0]                    vcode_reg9_o,
    output logic [3:0]                    vcode_reg10_o,
    output logic [3:0]                    vcode_reg11_o,
    output logic [4:0]                    charger_one_o,
    output logic                          main_charger_disable_o,
    output logic [1:0]                    eoc_select_o,
    output logic [7:0]                    ctrl_enable_o,
    output logic [1:0]                    adc_mux_o,
    output logic [1:0]                    adc_ctrl_o
);
    import pcrb_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_SKIP} pcrb_state_t;

    // Two-stage synchronisers for every pin sampled by the bank except the converter data and charging flag.
    localparam int NSYNC = 13;
    // SCL and SDA restart at their idle high level, so leaving reset shows no false edge.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h1800;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw_w = {scl_i, sda_i, powerup_start_i, battery_good_i, on_key_i, alarm_i,
                    charger_supply_input_i, handsfree_wake_input_i, comparator_one_result_i,
                    comparator_two_result_i, adc_overflow_i, adc_ready_i, eoc_flag_i};
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
        end else begin
            s1_q <= raw_w;
            s2_q <= s1_q;
        end
    end
    logic scl_w, sda_w, pup_w, batt_w, key_w, alm_w, chg_w, hf_w, c1_w, c2_w, ovf_w, rdy_w, eoc_w;
    assign {scl_w, sda_w, pup_w, batt_w, key_w, alm_w, chg_w, hf_w, c1_w, c2_w, ovf_w, rdy_w, eoc_w} = s2_q;

    // The converter data and charging flag are assumed to come from logic on this clock.
    logic scl_d1_q, sda_d1_q, pup_d1_q;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
            pup_d1_q <= 1'b0;
        end else begin
            scl_d1_q <= scl_w;
            sda_d1_q <= sda_w;
            pup_d1_q <= pup_w;
        end
    end
    logic scl_rise_w, scl_fall_w, start_w, stop_w;
    assign scl_rise_w = scl_w & ~scl_d1_q;
    assign scl_fall_w = ~scl_w & scl_d1_q;
    assign start_w    = scl_w & scl_d1_q & sda_d1_q & ~sda_w;
    assign stop_w     = scl_w & scl_d1_q & ~sda_d1_q & sda_w;

    // Register storage, written as whole bytes through a per-register mask.
    // Registers clear to zero; loading power-up defaults is left to the sequencer outside.
    localparam int NREG = 12;
    logic [7:0] regs_q [NREG];
    logic [7:0] wm_w   [NREG];
    assign wm_w  = '{WM_FULL, WM_FULL, WM_FULL, WM_VPAIR_C, WM_FULL, WM_VREG3,
                     WM_VREG3, WM_VREG3, WM_CHG_ONE, WM_CHG_TWO, WM_FULL, WM_ADC_CTRL};

    pcrb_state_t st_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic [7:0]  ptr_q;
    logic        ack_q;
    logic        rd_q;
    logic        drive_q;
    logic        wr_pulse_q;
    logic [7:0]  wr_data_q;
    logic [7:0]  reason_q;
    logic [7:0]  rdata_w;
    logic [7:0]  status_w;

    assign status_w = {c2_w, c1_w, key_w, alm_w, chg_w, hf_w, ovf_w, rdy_w};

    logic [7:0] chg_two_rd_w;
    assign chg_two_rd_w = {3'b000, eoc_w, charging_i, regs_q[9][2:0]};

    always_comb begin
        rdata_w = 8'h00;
        if (ptr_q < 8'(NREG)) begin
            rdata_w = regs_q[ptr_q[3:0]] & wm_w[ptr_q[3:0]];
        end
        if (ptr_q == OFS_CHG_TWO) begin
            rdata_w = chg_two_rd_w;
        end
        if (ptr_q == OFS_CONV_RESULT) begin
            rdata_w = adc_data_i;
        end
        if (ptr_q == OFS_WAKE_REASON) begin
            rdata_w = reason_q;
        end
        if (ptr_q == OFS_LIVE_STATUS) begin
            rdata_w = status_w;
        end
    end

    // Serial target: bits taken on rising clock, our drive changes on falling clock.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q       <= ST_IDLE;
            bit_q      <= 4'd0;
            sh_q       <= 8'h00;
            ptr_q      <= 8'h00;
            ack_q      <= 1'b0;
            rd_q       <= 1'b0;
            drive_q    <= 1'b0;
            wr_pulse_q <= 1'b0;
            wr_data_q  <= 8'h00;
        end else begin
            wr_pulse_q <= 1'b0;
            if (start_w) begin
                st_q    <= ST_ADDR;
                bit_q   <= 4'd0;
                ack_q   <= 1'b0;
                drive_q <= 1'b0;
            end else if (stop_w) begin
                st_q    <= ST_IDLE;
                drive_q <= 1'b0;
            end else if (st_q != ST_IDLE && st_q != ST_SKIP) begin
                if (scl_rise_w) begin
                    if (ack_q) begin
                        if (rd_q && st_q == ST_RDATA && sda_w) begin
                            st_q <= ST_SKIP;
                        end
                    end else begin
                        // A read byte keeps its own shifter, so only the count moves here.
                        if (st_q != ST_RDATA) begin
                            sh_q <= {sh_q[6:0], sda_w};
                        end
                        bit_q <= bit_q + 4'd1;
                    end
                end
                if (scl_fall_w) begin
                    if (ack_q) begin
                        ack_q   <= 1'b0;
                        drive_q <= 1'b0;
                        if (st_q == ST_RDATA) begin
                            drive_q <= ~rdata_w[7];
                            sh_q    <= {rdata_w[6:0], 1'b1};
                        end
                    end else if (bit_q == 4'd8) begin
                        // The fall ending a start also shows a zero count, so only a full byte opens the slot.
                        bit_q <= 4'd0;
                        ack_q <= 1'b1;
                        case (st_q)
                            ST_ADDR: begin
                                if (sh_q[7:1] == TARGET_ADDR) begin
                                    drive_q <= 1'b1;
                                    rd_q    <= sh_q[0];
                                    st_q    <= sh_q[0] ? ST_RDATA : ST_REG;
                                end else begin
                                    st_q  <= ST_SKIP;
                                    ack_q <= 1'b0;
                                end
                            end
                            ST_REG: begin
                                drive_q <= 1'b1;
                                ptr_q   <= sh_q;
                                st_q    <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                drive_q    <= 1'b1;
                                wr_pulse_q <= 1'b1;
                                wr_data_q  <= sh_q;
                            end
                            ST_RDATA: begin
                                drive_q <= 1'b0;
                                ptr_q   <= ptr_q + 8'd1;
                            end
                            default: begin
                                drive_q <= 1'b0;
                            end
                        endcase
                    end else if (st_q == ST_RDATA) begin
                        drive_q <= ~sh_q[7];
                        sh_q    <= {sh_q[6:0], 1'b1};
                    end
                end
            end
            if (wr_pulse_q) begin
                ptr_q <= ptr_q + 8'd1;
            end
        end
    end

    // The first read byte is loaded when the address acknowledge ends.
    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_q;

    logic wr_hit_w;
    assign wr_hit_w = wr_pulse_q && (ptr_q < 8'(NREG));

    generate
        for (genvar g = 0; g < NREG; g++) begin : g_reg
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    regs_q[g] <= 8'h00;
                end else if (wr_hit_w && ptr_q[3:0] == 4'(g)) begin
                    regs_q[g] <= (regs_q[g] & ~wm_w[g]) | (wr_data_q & wm_w[g]);
                end
            end
        end
    endgenerate

    // Reason capture; reset leaves it clear until the first power-up start.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reason_q <= 8'h00;
        end else if (pup_w && !pup_d1_q) begin
            reason_q <= {4'h0, key_w, alm_w, chg_w & batt_w, hf_w};
        end
    end

    assign reg_enable_o          = regs_q[0];
    assign vcode_reg1_o          = regs_q[1][3:0];
    assign vcode_reg9_o          = regs_q[1][7:4];
    assign vcode_reg2_o          = regs_q[2][3:0];
    assign vcode_reg10_o         = regs_q[2][7:4];
    assign vcode_reg3_o          = regs_q[3][2:0];
    assign vcode_reg8_o          = regs_q[3][6:4];
    assign vcode_reg4_o          = regs_q[4][3:0];
    assign vcode_reg11_o         = regs_q[4][7:4];
    assign vcode_reg5_o          = regs_q[5][2:0];
    assign vcode_reg6_o          = regs_q[6][2:0];
    assign vcode_reg7_o          = regs_q[7][2:0];
    assign charger_one_o         = regs_q[8][4:0];
    assign main_charger_disable_o = regs_q[9][CHG_TWO_DIS_BIT];
    assign eoc_select_o          = regs_q[9][CHG_TWO_EOC_LSB +: 2];
    assign ctrl_enable_o         = regs_q[10];
    assign adc_mux_o             = regs_q[11][ADC_MUX_LSB +: 2];
    assign adc_ctrl_o            = regs_q[11][3:2];
endmodule // pcrb_bank

// >>> rtl/pcrb_pkg.sv
// Package with the register map, field positions and reset values of the control register bank.
package pcrb_pkg;
    localparam logic [6:0] TARGET_ADDR       = 7'h7E;
    localparam logic [7:0] OFS_REG_EN        = 8'h00;
    localparam logic [7:0] OFS_VPAIR_A       = 8'h01;
    localparam logic [7:0] OFS_VPAIR_B       = 8'h02;
    localparam logic [7:0] OFS_VPAIR_C       = 8'h03;
    localparam logic [7:0] OFS_VPAIR_D       = 8'h04;
    localparam logic [7:0] OFS_VREG5         = 8'h05;
    localparam logic [7:0] OFS_VREG6         = 8'h06;
    localparam logic [7:0] OFS_VREG7         = 8'h07;
    localparam logic [7:0] OFS_CHG_ONE       = 8'h08;
    localparam logic [7:0] OFS_CHG_TWO       = 8'h09;
    localparam logic [7:0] OFS_CTRL_EN       = 8'h0A;
    localparam logic [7:0] OFS_ADC_CTRL      = 8'h0B;
    localparam logic [7:0] OFS_CONV_RESULT   = 8'h0C;
    localparam logic [7:0] OFS_WAKE_REASON   = 8'h0D;
    localparam logic [7:0] OFS_LIVE_STATUS   = 8'h2E;
    localparam logic [7:0] RST_REG_EN        = 8'h2A;
    localparam logic [7:0] RST_VPAIR_A       = 8'hF3;
    localparam logic [7:0] RST_VPAIR_B       = 8'hAD;
    localparam logic [7:0] RST_VPAIR_C       = 8'h55;
    localparam logic [7:0] RST_VPAIR_D       = 8'h0F;
    localparam logic [7:0] RST_VREG5         = 8'h03;
    localparam logic [7:0] RST_VREG6         = 8'h03;
    localparam logic [7:0] RST_VREG7         = 8'h05;
    localparam logic [7:0] RST_CHG_ONE       = 8'h11;
    localparam logic [7:0] RST_CHG_TWO       = 8'h02;
    localparam logic [7:0] RST_CTRL_EN       = 8'h10;
    localparam logic [7:0] RST_ADC_CTRL      = 8'h03;
    // Writable masks; bits outside them are read-only or unused.
    localparam logic [7:0] WM_FULL           = 8'hFF;
    localparam logic [7:0] WM_VPAIR_C        = 8'h77;
    localparam logic [7:0] WM_VREG3          = 8'h07;
    localparam logic [7:0] WM_CHG_ONE        = 8'h1F;
    localparam logic [7:0] WM_CHG_TWO        = 8'h07;
    localparam logic [7:0] WM_ADC_CTRL       = 8'h0F;
    localparam int         CHG_TWO_DIS_BIT   = 0;
    localparam int         CHG_TWO_EOC_LSB   = 1;
    localparam int         CHG_TWO_CHARGING  = 3;
    localparam int         CHG_TWO_EOC_FLAG  = 4;
    localparam int         ADC_MUX_LSB       = 0;
endpackage : pcrb_pkg

// >>> test/pcrb_bank_asserts.sv
// Port-level assertions of the control register bank, bound onto the design.
module pcrb_bank_asserts (
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    input wire logic       scl_i,
    input wire logic       sda_oe_o,
    input wire logic [7:0] reg_enable_o,
    input wire logic [3:0] vcode_reg1_o,
    input wire logic [3:0] vcode_reg2_o,
    input wire logic [3:0] vcode_reg9_o,
    input wire logic       main_charger_disable_o,
    input wire logic [1:0] adc_mux_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // The target may only move SDA while SCL is low, so a host never sees a false start or stop.
    property p_ack_start; $rose(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
    a_ack_start: assert property (p_ack_start) else $error("drive began with SCL high");
    property p_ack_end; $fell(sda_oe_o) |-> !scl_i; endproperty
    a_ack_end: assert property (p_ack_end) else $error("drive ended with SCL high");
    property p_held_high; scl_i && $past(scl_i, 4) |-> $stable(sda_oe_o); endproperty
    a_held_high: assert property (p_held_high) else $error("SDA moved in SCL high");
    property p_enable_write; $changed(reg_enable_o) |-> !scl_i && $stable(vcode_reg1_o); endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable update misplaced");
    property p_pair_write; $changed(vcode_reg9_o) |-> !scl_i && $stable(reg_enable_o); endproperty
    a_pair_write: assert property (p_pair_write) else $error("pair update misplaced");
    property p_code_apart; $changed(vcode_reg1_o) |-> $stable(reg_enable_o) && $stable(vcode_reg2_o); endproperty
    a_code_apart: assert property (p_code_apart) else $error("code tied to enable");
    property p_dis_write; $changed(main_charger_disable_o) |-> !scl_i && $stable(adc_mux_o); endproperty
    a_dis_write: assert property (p_dis_write) else $error("disable update misplaced");
    property p_mux_write; $changed(adc_mux_o) |-> !scl_i && $stable(main_charger_disable_o); endproperty
    a_mux_write: assert property (p_mux_write) else $error("select update misplaced");
endmodule // pcrb_bank_asserts

bind pcrb_bank pcrb_bank_asserts u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .reg_enable_o(reg_enable_o), .vcode_reg1_o(vcode_reg1_o), .vcode_reg2_o(vcode_reg2_o),
    .vcode_reg9_o(vcode_reg9_o), .main_charger_disable_o(main_charger_disable_o), .adc_mux_o(adc_mux_o));

// >>> test/pcrb_host.sv
// Behavioural serial host that moves whole bytes to and from the register bank.
module pcrb_host
    import pcrb_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {scl_o, sda_low_o} = 2'b10;
    // Data moves one cycle after SCL falls so both synchronised lines never change together.
    task automatic bit_io(input logic b, output logic r);
        @(negedge clk_i);
        sda_low_o = ~b;
        repeat (8) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (8) @(negedge clk_i);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic cond(input logic s);
        @(negedge clk_i);
        sda_low_o = ~s;
        repeat (8) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (8) @(negedge clk_i);
        sda_low_o = s;
        repeat (8) @(negedge clk_i);
        scl_o = ~s;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, r);
        ak = ~r;
    endtask
    task automatic xact(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, input logic rnw,
                        output logic [7:0] rx, output logic ak);
        logic [7:0] x;
        logic       a0, a1, a2, a3;
        a2 = 1'b0;
        cond(1'b1);
        xfer({dev, 1'b0}, x, a0);
        xfer(ra, x, a1);
        if (rnw) begin
            cond(1'b1);
            xfer({dev, 1'b1}, x, a2);
        end
        xfer(rnw ? 8'hFF : d, rx, a3);
        cond(1'b0);
        ak = a0 & a1 & (rnw ? a2 : a3);
    endtask
endmodule // pcrb_host

// >>> test/test_pcrb_bank.sv
// Self-checking testbench of the control register bank driven through the serial host.
module test_pcrb_bank;
    import pcrb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys_i, arst_n, scl, sda_low, sda_line, oe, sdo, ak, dis;
    logic       pwr, bgood, key, alm, chg, hf, c1, c2, ovf, rdy, eoc, chgn;
    logic [7:0] adc, en, got, cen;
    logic [4:0] chg1;
    logic [3:0] v1, v2, v4, v9, v10, v11;
    logic [2:0] v3, v5, v6, v7, v8;
    logic [1:0] eos, mux, actl;
    int         errors = 0, checked = 0, cyc = 0;
    // SDA has a pull-up, so it is high unless some party pulls it down.
    assign sda_line = ~(sda_low | (oe & ~sdo));
    pcrb_bank dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sdo), .sda_oe_o(oe),
        .powerup_start_i(pwr), .battery_good_i(bgood), .on_key_i(key), .alarm_i(alm),
        .charger_supply_input_i(chg), .handsfree_wake_input_i(hf), .comparator_one_result_i(c1),
        .comparator_two_result_i(c2), .adc_overflow_i(ovf), .adc_ready_i(rdy), .adc_data_i(adc),
        .eoc_flag_i(eoc), .charging_i(chgn), .reg_enable_o(en), .vcode_reg1_o(v1), .vcode_reg2_o(v2),
        .vcode_reg3_o(v3), .vcode_reg4_o(v4), .vcode_reg5_o(v5), .vcode_reg6_o(v6), .vcode_reg7_o(v7),
        .vcode_reg8_o(v8), .vcode_reg9_o(v9), .vcode_reg10_o(v10), .vcode_reg11_o(v11), .charger_one_o(chg1),
        .main_charger_disable_o(dis), .eoc_select_o(eos), .ctrl_enable_o(cen), .adc_mux_o(mux),
        .adc_ctrl_o(actl)
    );
    pcrb_host host (.clk_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 60000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xact(TARGET_ADDR, a, d, 1'b0, got, ak);
        chk("write ack", {7'h00, ak}, 8'h01);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        host.xact(TARGET_ADDR, a, 8'h00, 1'b1, got, ak);
        chk("read ack", {7'h00, ak}, 8'h01);
        chk(n, got, e);
    endtask
    initial begin
        {pwr, bgood, key, alm, chg, hf, c1, c2, ovf, rdy, eoc, chgn} = '0;
        adc = 8'hA5;
        arst_n = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rdc("enable", OFS_REG_EN, 8'h00);
        wr(OFS_VPAIR_A, 8'h8C);
        chk("reg9 reg1", {v9, v1}, 8'h8C);
        wr(OFS_REG_EN, 8'hFF);
        chk("enables", en, 8'hFF);
        wr(OFS_VPAIR_B, 8'hF0);
        chk("reg10 reg2", {v10, v2}, 8'hF0);
        wr(OFS_VPAIR_C, 8'hFF);
        rdc("unused bits", OFS_VPAIR_C, 8'h77);
        chk("reg8 reg3", {1'b0, v8, 1'b0, v3}, 8'h77);
        wr(OFS_VPAIR_D, 8'hF0);
        chk("reg11 reg4", {v11, v4}, 8'hF0);
        wr(OFS_VREG5, 8'hFE);
        chk("reg5", {5'h00, v5}, 8'h06);
        wr(OFS_VREG6, 8'hFD);
        chk("reg6", {5'h00, v6}, 8'h05);
        wr(OFS_VREG7, 8'hFB);
        chk("reg7", {5'h00, v7}, 8'h03);
        wr(OFS_CHG_ONE, 8'hFF);
        chk("charger one", {3'h0, chg1}, 8'h1F);
        wr(OFS_CTRL_EN, 8'hA5);
        chk("control enable", cen, 8'hA5);
        eoc = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CHG_TWO, 8'hF8 | 8'(i));
            chk("charger ctl", {5'h0, eos, dis}, 8'(i));
        end
        rdc("charger reg", OFS_CHG_TWO, 8'h17);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_ADC_CTRL, 8'(i));
            chk("adc select", {6'h0, mux}, 8'(i));
        end
        wr(OFS_ADC_CTRL, 8'hFF);
        chk("adc control", {4'h0, actl, mux}, 8'h0F);
        host.xact(7'h3C, OFS_REG_EN, 8'h00, 1'b0, got, ak);
        chk("foreign address", {ak, en[6:0]}, 8'h7F);
        wr(OFS_CONV_RESULT, 8'h00);
        rdc("converter", OFS_CONV_RESULT, 8'hA5);
        for (int i = 0; i < 8; i++) begin
            {c2, c1, key, alm, chg, hf, ovf, rdy} = 8'h01 << i;
            rdc("status", OFS_LIVE_STATUS, 8'h01 << i);
        end
        {key, alm, chg, hf} = 4'hB;
        repeat (8) @(negedge clk_sys_i);
        pwr = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        pwr = 1'b0;
        rdc("reason", OFS_WAKE_REASON, 8'h09);
        {key, alm, bgood} = 3'b011;
        wr(OFS_WAKE_REASON, 8'hFF);
        rdc("reason held", OFS_WAKE_REASON, 8'h09);
        pwr = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        pwr = 1'b0;
        rdc("reason multi", OFS_WAKE_REASON, 8'h07);
        arst_n = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk("enable in reset", en, 8'h00);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rdc("reason cleared", OFS_WAKE_REASON, 8'h00);
        chk("sda level", {7'h00, sdo}, 8'h00);
        report_and_stop();
    end
endmodule // test_pcrb_bank
